//--- common/spem_pkg.sv
// Constants and types shared by the serial port error monitor.
// Assumes a single 25 MHz clock and byte addresses on the register bus.
package spem_pkg;

  localparam int CLK_HZ    = 25_000_000;
  localparam int TICK_MS   = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int NPORT     = 2;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_MASK    = 8'h04;
  localparam logic [7:0] REG_FSEL    = 8'h08;
  localparam logic [7:0] REG_PEER_TO = 8'h0C;
  localparam logic [4:0] PO_CFG      = 5'h00;
  localparam logic [4:0] PO_TEL_TO   = 5'h04;
  localparam logic [4:0] PO_RXDATA   = 5'h08;
  localparam logic [4:0] PO_EVENT    = 5'h0C;
  localparam logic [4:0] PO_DIAG0    = 5'h10;
  localparam logic [4:0] PO_DIAG1    = 5'h14;
  localparam logic [4:0] PO_DIAG2    = 5'h18;
  localparam logic [4:0] PO_DIAG3    = 5'h1C;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0]  CHK_CODE_A    = 4'h1;
  localparam logic [3:0]  CHK_CODE_B    = 4'h9;
  localparam logic [15:0] FSEL_DOWNLOAD = 16'h0017;
  localparam logic [3:0]  OP_STATE_PEER = 4'h6;
  localparam int CFG_PAR_LSB   = 4;
  localparam int CFG_STOP2_BIT = 6;
  localparam int CFG_DIV_LSB   = 16;
  localparam logic [1:0]  PAR_NONE = 2'h0;
  localparam logic [1:0]  PAR_ODD  = 2'h2;
  localparam logic [31:0] CFG_RESET    = 32'h0A2C_0000;
  localparam logic [15:0] TEL_TO_RESET = 16'h0000;
  localparam logic [15:0] FSEL_RESET   = 16'h0000;

  localparam int EV_OP_LSB  = 29;
  localparam int EV_IDX_LSB = 16;
  localparam logic [2:0] EV_VALID = 3'h1;
  localparam logic [2:0] EV_ERROR = 3'h2;
  localparam logic [2:0] EV_END   = 3'h3;
  localparam logic [2:0] EV_PROTO = 3'h4;

  localparam int FLT_PARITY  = 0;
  localparam int FLT_FRAMING = 1;
  localparam int FLT_OVERRUN = 2;
  localparam int FLT_SYNTAX  = 3;
  localparam int FLT_TEL     = 4;
  localparam int FLT_PEER    = 5;
  localparam int FLT_STRIDE  = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spem_rx_e;

  typedef struct packed {
    spem_rx_e    st;
    logic [15:0] cnt;
    logic [2:0]  bitn;
    logic [7:0]  shreg;
    logic        par;
    logic        stop2;
    logic [7:0]  data;
    logic        full;
    logic        done;
    logic        pe;
    logic        fe;
    logic        oe;
  } spem_rx_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        fired;
    logic        expire;
  } spem_wd_s;

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] tel_to;
    logic        proto_seen;
    logic [15:0] last_param;
    logic [11:0] last_index;
    logic        err_pend;
    logic [2:0]  diag0;
    logic [15:0] diag1;
    logic [15:0] diag2;
    logic [11:0] diag3;
  } spem_port_s;

  typedef struct packed {
    logic [15:0]                 status;
    logic [15:0]                 mask;
    logic [15:0]                 fsel;
    logic [15:0]                 peer_to;
    logic                        ack;
    logic [31:0]                 rdata;
    logic [15:0]                 presc;
    logic                        tick;
    spem_port_s [NPORT-1:0]      port;
  } spem_top_s;

endpackage : spem_pkg

//--- hw/spem_rx.sv
// Receiver for one serial port with parity, stop bit and overrun checks.
// Assumes rxd is already synchronous to mclk and idles high.
`timescale 1ns/1ps
module spem_rx
  import spem_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Line and frame setup
  input  wire logic        rxd,
  input  wire logic [15:0] divisor,
  input  wire logic [1:0]  parity_mode,
  input  wire logic        two_stop,
  // Buffer
  input  wire logic        take,
  output logic      [7:0]  data,
  output logic             full,
  // Events
  output logic             byte_done,
  output logic             perr,
  output logic             ferr,
  output logic             oerr
);

  spem_rx_s s_reg;
  spem_rx_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    s_next.pe   = 1'b0;
    s_next.fe   = 1'b0;
    s_next.oe   = 1'b0;
    if (take) begin
      s_next.full = 1'b0;
    end
    unique case (s_reg.st)
      RX_IDLE: if (!rxd) begin
        s_next.st  = RX_START;
        s_next.cnt = {1'b0, divisor[15:1]};
      end
      RX_START: if (s_reg.cnt != 16'h0000) begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end else if (rxd) begin
        s_next.st = RX_IDLE;
      end else begin
        s_next.st   = RX_DATA;
        s_next.cnt  = divisor - 16'h0001;
        s_next.bitn = 3'h0;
        s_next.par  = 1'b0;
      end
      RX_DATA: if (s_reg.cnt != 16'h0000) begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end else begin
        s_next.shreg = {rxd, s_reg.shreg[7:1]};
        s_next.par   = s_reg.par ^ rxd;
        s_next.cnt   = divisor - 16'h0001;
        s_next.bitn  = s_reg.bitn + 3'h1;
        s_next.stop2 = 1'b0;
        if (s_reg.bitn == 3'h7) begin
          s_next.st = (parity_mode != PAR_NONE) ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: if (s_reg.cnt != 16'h0000) begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end else begin
        s_next.pe  = (s_reg.par ^ rxd) != (parity_mode == PAR_ODD);
        s_next.cnt = divisor - 16'h0001;
        s_next.st  = RX_STOP;
      end
      RX_STOP: if (s_reg.cnt != 16'h0000) begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end else if (!rxd) begin
        s_next.fe = 1'b1;
        s_next.st = RX_IDLE;
      end else if (two_stop && !s_reg.stop2) begin
        s_next.stop2 = 1'b1;
        s_next.cnt   = divisor - 16'h0001;
      end else begin
        s_next.oe   = s_reg.full && !take;
        s_next.done = 1'b1;
        s_next.data = s_reg.shreg;
        s_next.full = 1'b1;
        s_next.st   = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '{st: RX_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign data      = s_reg.data;
  assign full      = s_reg.full;
  assign byte_done = s_reg.done;
  assign perr      = s_reg.pe;
  assign ferr      = s_reg.fe;
  assign oerr      = s_reg.oe;

endmodule : spem_rx

//--- hw/spem_top.sv
// Error monitor for two serial ports with an Avalon-MM register slave.
// Assumes synchronous rxd lines, an op_state input from the drive, and
// firmware that parses download text and reports its events by register.
`timescale 1ns/1ps
module spem_top
  import spem_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial lines
  input  wire logic [1:0]  rxd,
  // Drive state
  input  wire logic [3:0]  op_state,
  // Interrupt
  output logic             irq
);

  spem_top_s s_reg;
  spem_top_s s_next;

  logic [NPORT-1:0] take;
  logic [NPORT-1:0] rx_full;
  logic [NPORT-1:0] rx_done;
  logic [NPORT-1:0] rx_pe;
  logic [NPORT-1:0] rx_fe;
  logic [NPORT-1:0] rx_oe;
  logic [NPORT-1:0] tel_exp;
  logic [NPORT-1:0] peer_exp;
  logic [7:0]       rx_data [NPORT];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic chk_en(input logic [31:0] cfg);
    return (cfg[3:0] == CHK_CODE_A) || (cfg[3:0] == CHK_CODE_B);
  endfunction : chk_en

  function automatic logic port_hit(input logic [7:0] addr, input int p);
    return addr[7:5] == 3'(p + 1);
  endfunction : port_hit

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (val & m);
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // Per-port receivers and watchdogs.

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    logic [31:0] cfg;
    assign cfg = s_reg.port[g].cfg;

    spem_rx u_rx (
      .mclk        (mclk),
      .rst         (rst),
      .rxd         (rxd[g]),
      .divisor     (cfg[CFG_DIV_LSB +: 16]),
      .parity_mode (cfg[CFG_PAR_LSB +: 2]),
      .two_stop    (cfg[CFG_STOP2_BIT]),
      .take        (take[g]),
      .data        (rx_data[g]),
      .full        (rx_full[g]),
      .byte_done   (rx_done[g]),
      .perr        (rx_pe[g]),
      .ferr        (rx_fe[g]),
      .oerr        (rx_oe[g])
    );

    spem_wdog u_tel (
      .mclk   (mclk),
      .rst    (rst),
      .tick   (s_reg.tick),
      .armed  (s_reg.port[g].proto_seen),
      .kick   (rx_done[g]),
      .limit  (s_reg.port[g].tel_to),
      .expire (tel_exp[g])
    );

    spem_wdog u_peer (
      .mclk   (mclk),
      .rst    (rst),
      .tick   (s_reg.tick),
      .armed  (s_reg.port[g].proto_seen && (op_state >= OP_STATE_PEER)),
      .kick   (rx_done[g]),
      .limit  (s_reg.peer_to),
      .expire (peer_exp[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and fault collection.

  always_comb begin
    logic        wr;
    logic        rd;
    logic        syn_en;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [31:0] t;
    logic [4:0]  off;
    logic [2:0]  op;
    wr     = avs_write && s_reg.ack;
    rd     = avs_read && !s_reg.ack;
    syn_en = 1'b0;
    set_v  = 16'h0000;
    clr_v  = 16'h0000;
    t      = 32'h0000_0000;
    off    = {avs_address[4:2], 2'b00};
    op     = avs_writedata[EV_OP_LSB +: 3];
    take   = '0;
    s_next = s_reg;

    s_next.ack  = (avs_read || avs_write) && !s_reg.ack;
    s_next.tick = 1'b0;
    if (s_reg.presc == 16'(MS_TICK_CYCLES - 1)) begin
      s_next.presc = 16'h0000;
      s_next.tick  = 1'b1;
    end else begin
      s_next.presc = s_reg.presc + 16'h0001;
    end

    if (wr) begin
      unique case ({avs_address[7:2], 2'b00})
        REG_STATUS: begin
          t     = wmerge(32'h0000_0000, avs_writedata, avs_byteenable);
          clr_v = t[15:0];
        end
        REG_MASK: begin
          t            = wmerge({16'h0000, s_reg.mask}, avs_writedata, avs_byteenable);
          s_next.mask  = t[15:0];
        end
        REG_FSEL: begin
          t            = wmerge({16'h0000, s_reg.fsel}, avs_writedata, avs_byteenable);
          s_next.fsel  = t[15:0];
        end
        REG_PEER_TO: begin
          t              = wmerge({16'h0000, s_reg.peer_to}, avs_writedata, avs_byteenable);
          s_next.peer_to = t[15:0];
        end
        default: ;
      endcase
    end

    for (int p = 0; p < NPORT; p++) begin
      if (chk_en(s_reg.port[p].cfg)) begin
        set_v[p*FLT_STRIDE+FLT_PARITY]  = rx_pe[p];
        set_v[p*FLT_STRIDE+FLT_FRAMING] = rx_fe[p];
        set_v[p*FLT_STRIDE+FLT_OVERRUN] = rx_oe[p];
      end
      set_v[p*FLT_STRIDE+FLT_TEL]  = tel_exp[p];
      set_v[p*FLT_STRIDE+FLT_PEER] = peer_exp[p];
      syn_en = (s_reg.port[p].cfg[3:0] == CHK_CODE_A) && (s_reg.fsel == FSEL_DOWNLOAD);
      take[p] = avs_read && s_reg.ack && port_hit(avs_address, p) && (off == PO_RXDATA);

      if (wr && port_hit(avs_address, p)) begin
        unique case (off)
          PO_CFG:    s_next.port[p].cfg = wmerge(s_reg.port[p].cfg, avs_writedata,
                                                 avs_byteenable);
          PO_TEL_TO: begin
            t                     = wmerge({16'h0000, s_reg.port[p].tel_to}, avs_writedata,
                                           avs_byteenable);
            s_next.port[p].tel_to = t[15:0];
          end
          PO_EVENT: begin
            if (op == EV_VALID) begin
              s_next.port[p].last_param = avs_writedata[15:0];
              s_next.port[p].last_index = avs_writedata[EV_IDX_LSB +: 12];
            end
            if (op == EV_ERROR && syn_en) begin
              s_next.port[p].err_pend = 1'b1;
              s_next.port[p].diag0 = avs_writedata[2:0];
              s_next.port[p].diag2 = s_reg.port[p].last_param;
              s_next.port[p].diag3 = s_reg.port[p].last_index;
            end
            if (op == EV_END) begin
              s_next.port[p].diag1    = s_reg.port[p].last_param;
              set_v[p*FLT_STRIDE+FLT_SYNTAX] = s_reg.port[p].err_pend && syn_en;
              s_next.port[p].err_pend = 1'b0;
            end
            if (op == EV_PROTO) begin
              s_next.port[p].proto_seen = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end

    s_next.status = (s_reg.status & ~clr_v) | set_v;

    if (rd) begin
      s_next.rdata = 32'h0000_0000;
      unique case ({avs_address[7:2], 2'b00})
        REG_STATUS:  s_next.rdata = {16'h0000, s_reg.status};
        REG_MASK:    s_next.rdata = {16'h0000, s_reg.mask};
        REG_FSEL:    s_next.rdata = {16'h0000, s_reg.fsel};
        REG_PEER_TO: s_next.rdata = {16'h0000, s_reg.peer_to};
        default: ;
      endcase
      for (int p = 0; p < NPORT; p++) begin
        if (port_hit(avs_address, p)) begin
          unique case (off)
            PO_CFG:    s_next.rdata = s_reg.port[p].cfg;
            PO_TEL_TO: s_next.rdata = {16'h0000, s_reg.port[p].tel_to};
            PO_RXDATA: s_next.rdata = {23'h00_0000, rx_full[p], rx_data[p]};
            PO_EVENT:  s_next.rdata = {30'h0000_0000, s_reg.port[p].err_pend,
                                       s_reg.port[p].proto_seen};
            PO_DIAG0:  s_next.rdata = {29'h0000_0000, s_reg.port[p].diag0};
            PO_DIAG1:  s_next.rdata = {16'h0000, s_reg.port[p].diag1};
            PO_DIAG2:  s_next.rdata = {16'h0000, s_reg.port[p].diag2};
            PO_DIAG3:  s_next.rdata = {20'h0_0000, s_reg.port[p].diag3};
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      for (int p = 0; p < NPORT; p++) begin
        s_reg.port[p].cfg    <= CFG_RESET;
        s_reg.port[p].tel_to <= TEL_TO_RESET;
      end
      s_reg.fsel <= FSEL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and interrupt outputs.

  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
  assign irq             = |(s_reg.status & s_reg.mask);

endmodule : spem_top

//--- hw/spem_wdog.sv
// Telegram gap watchdog counting millisecond ticks.
// Assumes tick is a one-cycle pulse each millisecond; limit zero disables.
`timescale 1ns/1ps
module spem_wdog
  import spem_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Control
  input  wire logic        tick,
  input  wire logic        armed,
  input  wire logic        kick,
  input  wire logic [15:0] limit,
  // Event
  output logic             expire
);

  spem_wd_s s_reg;
  spem_wd_s s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.expire = 1'b0;
    if (!armed || kick) begin
      s_next.cnt   = 16'h0000;
      s_next.fired = 1'b0;
    end else if (tick && !s_reg.fired && limit != 16'h0000) begin
      if (s_reg.cnt == limit) begin
        s_next.expire = 1'b1;
        s_next.fired  = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expire = s_reg.expire;

endmodule : spem_wdog

//--- testbench/serial_port_error_monitor_bench.sv
// Self-checking bench of the error monitor with seeded random data.
// Assumes the remote sender models on both lines and the bound checker.
`timescale 1ns/1ps
module serial_port_error_monitor_bench
  import spem_pkg::*;
;
  localparam int          DIV = 16;
  localparam logic [31:0] A   = 32'hFFFF_FFFF;
  localparam logic [31:0] Z   = 32'h0000_0000;
  logic        mclk           = 1'b0;
  logic        rst            = 1'b1;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [7:0]  avs_address    = 8'h00;
  logic [31:0] avs_writedata  = Z;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [3:0]  op_state       = 4'h0;
  logic [31:0] seed           = 32'h0000_0057;
  logic [31:0] avs_readdata;
  logic [31:0] rd_v;
  logic        avs_waitrequest;
  logic        irq;
  wire  [1:0]  rxd;
  int          fails          = 0;
  int          cmp_count      = 0;
  always #20 mclk = ~mclk;
  spem_top #(.MS_TICK_CYCLES(10)) dut_u (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rxd, .op_state, .irq
  );
  spem_remote #(.DIV(DIV)) rem0_u (.mclk, .txd(rxd[0]));
  spem_remote #(.DIV(DIV)) rem1_u (.mclk, .txd(rxd[1]));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] fb(input int p, input int k);
    return 32'h0000_0001 << (FLT_STRIDE * p + k);
  endfunction : fb
  function automatic logic [31:0] cfg(input logic [1:0] pm, input logic [3:0] c);
    return {16'(DIV), 10'h000, pm, c};
  endfunction : cfg
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      chk(Z, A, "bus hang");
      wrap_up();
    end
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e,
                    input string m);
    bus(1'b0, a, Z);
    chk(rd_v & k, e, m);
  endtask : rc
  task automatic ci(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask : ci
  task automatic tx(input int p, input logic [7:0] d, input logic [1:0] pm, input logic bp,
                    input logic bs);
    if (p == 0) rem0_u.send(d, pm, bp, bs);
    else rem1_u.send(d, pm, bp, bs);
  endtask : tx
  task automatic ev(input logic [7:0] b, input logic [2:0] op, input logic [28:0] v);
    bus(1'b1, b + PO_EVENT, {op, v});
  endtask : ev
  ////////////////////////////////////////////////////////////////////////////
  task automatic line_test(input int p);
    logic [7:0] b;
    logic [7:0] d;
    b = 8'(32 * (p + 1));
    d = 8'(rnd());
    bus(1'b1, b, cfg(PAR_ODD, 4'h0));
    tx(p, d, PAR_ODD, 1'b1, 1'b0);
    bus(1'b0, b + PO_RXDATA, Z);
    rc(REG_STATUS, A, Z, "off");
    bus(1'b1, b, cfg(2'h1, CHK_CODE_A));
    tx(p, d, 2'h1, 1'b0, 1'b0);
    rc(REG_STATUS, A, Z, "good");
    rc(b + PO_RXDATA, A, {23'h0, 1'b1, d}, "rx");
    rc(b + PO_RXDATA, 32'h0000_0100, Z, "pop");
    tx(p, ~d, 2'h1, 1'b1, 1'b0);
    bus(1'b0, b + PO_RXDATA, Z);
    rc(REG_STATUS, A, fb(p, FLT_PARITY), "parity");
    ci(1'b1);
    bus(1'b1, REG_MASK, Z);
    ci(1'b0);
    bus(1'b1, REG_MASK, 32'h0000_FFFF);
    bus(1'b1, REG_STATUS, fb(p, FLT_PARITY));
    rc(REG_STATUS, A, Z, "w1c");
    bus(1'b1, b, cfg(PAR_ODD, CHK_CODE_B));
    tx(p, d, PAR_ODD, 1'b0, 1'b0);
    tx(p, ~d, PAR_ODD, 1'b0, 1'b0);
    rc(REG_STATUS, A, fb(p, FLT_OVERRUN), "overrun");
    bus(1'b1, b, cfg(PAR_NONE, CHK_CODE_A));
    tx(p, d, PAR_NONE, 1'b0, 1'b1);
    rc(REG_STATUS, fb(p, FLT_FRAMING), fb(p, FLT_FRAMING), "framing");
    repeat (12 * DIV) @(posedge mclk);
    bus(1'b0, b + PO_RXDATA, Z);
    bus(1'b1, REG_STATUS, 32'h0000_FFFF);
    bus(1'b1, b, cfg(PAR_NONE, CHK_CODE_A) | (32'h0000_0001 << CFG_STOP2_BIT));
    tx(p, d, PAR_NONE, 1'b0, 1'b0);
    repeat (2 * DIV) @(posedge mclk);
    rc(b + PO_RXDATA, A, {23'h0, 1'b1, d}, "two stop");
    rc(REG_STATUS, A, Z, "two stop clean");
    bus(1'b1, b, cfg(PAR_NONE, CHK_CODE_A));
    $display("test line %0d done", p);
  endtask : line_test
  task automatic syn_test(input int p);
    logic [7:0]  b;
    logic [15:0] n1;
    logic [15:0] n2;
    logic [11:0] i1;
    b = 8'(32 * (p + 1));
    bus(1'b1, REG_FSEL, {16'h0000, FSEL_DOWNLOAD});
    for (int c = 1; c <= 6; c++) begin
      n1 = 16'(rnd());
      n2 = 16'(rnd());
      i1 = 12'(rnd());
      ev(b, EV_VALID, {1'b0, i1, n1});
      ev(b, EV_ERROR, 29'(c));
      ev(b, EV_VALID, {1'b0, 12'(rnd()), n2});
      rc(REG_STATUS, A, Z, "early");
      ev(b, EV_END, 29'h0);
      rc(REG_STATUS, A, fb(p, FLT_SYNTAX), "syntax");
      rc(b + PO_DIAG0, A, 32'(c), "diag0");
      rc(b + PO_DIAG1, A, {16'h0000, n2}, "diag1");
      rc(b + PO_DIAG2, A, {16'h0000, n1}, "diag2");
      rc(b + PO_DIAG3, A, {20'h0_0000, i1}, "diag3");
      bus(1'b1, REG_STATUS, fb(p, FLT_SYNTAX));
    end
    bus(1'b1, b, cfg(PAR_NONE, CHK_CODE_B));
    ev(b, EV_ERROR, 29'h1);
    ev(b, EV_END, 29'h0);
    bus(1'b1, b, cfg(PAR_NONE, CHK_CODE_A));
    bus(1'b1, REG_FSEL, Z);
    ev(b, EV_ERROR, 29'h2);
    ev(b, EV_END, 29'h0);
    rc(REG_STATUS, A, Z, "gated");
    rc(b + PO_DIAG0, A, 32'h0000_0006, "kept");
    $display("test syntax %0d done", p);
  endtask : syn_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rc(8'h20, A, CFG_RESET, "cfg0");
    rc(8'h40, A, CFG_RESET, "cfg1");
    rc(8'h24, A, Z, "tel_to");
    rc(REG_STATUS, A, Z, "status");
    bus(1'b1, 8'h10, rnd());
    rc(8'h10, A, Z, "unmapped");
    bus(1'b1, REG_MASK, 32'h0000_FFFF);
    rc(REG_MASK, A, 32'h0000_FFFF, "mask");
    avs_byteenable <= 4'h1;
    bus(1'b1, REG_MASK, Z);
    avs_byteenable <= 4'hF;
    rc(REG_MASK, A, 32'h0000_FF00, "lanes");
    bus(1'b1, REG_MASK, 32'h0000_FFFF);
    $display("test reset done");
    for (int p = 0; p < 2; p++) line_test(p);
    for (int p = 0; p < 2; p++) syn_test(p);
    bus(1'b1, 8'h24, 32'h0000_0003);
    bus(1'b1, 8'h44, 32'h0000_0008);
    bus(1'b1, REG_PEER_TO, 32'h0000_0002);
    op_state <= 4'h5;
    repeat (200) @(posedge mclk);
    rc(REG_STATUS, A, Z, "unarmed");
    ev(8'h20, EV_PROTO, 29'h0);
    ev(8'h40, EV_PROTO, 29'h0);
    repeat (50) @(posedge mclk);
    rc(REG_STATUS, A, fb(0, FLT_TEL), "tel0");
    repeat (80) @(posedge mclk);
    rc(REG_STATUS, A, fb(0, FLT_TEL) | fb(1, FLT_TEL), "tel1");
    op_state <= 4'(6 + rnd() % 10);
    repeat (60) @(posedge mclk);
    rc(REG_STATUS, A, 32'h0000_3030, "peer");
    $display("test timeout done");
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    chk(Z, A, "run hang");
    wrap_up();
  end
endmodule : serial_port_error_monitor_bench

//--- testbench/spem_props.sv
// Checker of bus timing, read layouts and interrupt level at the top ports.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module spem_props
  import spem_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Interrupt
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic ok;
  logic pt;
  assign ok = avs_read && !avs_waitrequest;
  assign pt = ok && (avs_address[7:5] != 3'h0);
  sequence s_start; $rose(avs_read || avs_write); endsequence
  sequence s_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_one_wait; s_start |-> s_answer; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait without request");
  property p_quiet; $past(rst) |-> !irq && avs_readdata == 32'h0000_0000; endproperty
  a_quiet: assert property (p_quiet) else $error("not quiet after reset");
  property p_irq_hold; irq && !avs_write |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_status;
    ok && avs_address == REG_STATUS |-> avs_readdata[31:16] == 16'h0000 &&
      avs_readdata[7:6] == 2'h0 && avs_readdata[15:14] == 2'h0;
  endproperty
  a_status: assert property (p_status) else $error("status layout");
  property p_rx; pt && avs_address[4:0] == PO_RXDATA |-> avs_readdata[31:9] == 23'h00_0000;
  endproperty
  a_rx: assert property (p_rx) else $error("rx data layout");
  property p_diag0; pt && avs_address[4:0] == PO_DIAG0 |-> avs_readdata <= 32'h0000_0006;
  endproperty
  a_diag0: assert property (p_diag0) else $error("cause code out of range");
  property p_diag3; pt && avs_address[4:0] == PO_DIAG3 |-> avs_readdata[31:12] == 20'h0_0000;
  endproperty
  a_diag3: assert property (p_diag3) else $error("index width");
endmodule : spem_props
bind spem_top spem_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) chk_u (
  .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .irq
);

//--- testbench/spem_remote.sv
// Remote sender model driving one serial line of the monitor.
// Assumes the caller passes the frame setup of the port it faces.
`timescale 1ns/1ps
module spem_remote
  import spem_pkg::*;
#(
  parameter int DIV = 16
)(
  // Clock
  input wire logic mclk,
  // Line
  output logic     txd
);
  initial txd = 1'b1;
  task automatic send(input logic [7:0] b, input logic [1:0] pm, input logic bp,
                      input logic bs);
    logic [11:0] fr;
    int          n;
    fr = {3'h7, b, 1'h0};
    n  = 10;
    if (pm != PAR_NONE) begin
      fr = {2'h3, ^b ^ pm[1] ^ bp, b, 1'h0};
      n  = 11;
    end
    fr[n - 1] = !bs;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      txd <= fr[i];
      repeat (DIV - 1) @(posedge mclk);
    end
    @(posedge mclk);
    txd <= 1'b1;
  endtask : send
endmodule : spem_remote
